// ==== logic/acs_pkg.sv ====
// ****************************************************************
// axis command acknowledge and status constants
// ****************************************************************
package acs_pkg;

	localparam int ACS_ADDR_W = 4;
	localparam int ACS_DATA_W = 16;

	// ****************************************************************
	// register offsets (word indices on the plain register port)
	// ****************************************************************
	localparam logic [3:0] ACS_OFS_CMD = 4'h0;
	localparam logic [3:0] ACS_OFS_ACK = 4'h1;
	localparam logic [3:0] ACS_OFS_STATUS = 4'h2;
	localparam logic [3:0] ACS_OFS_IRQ_STAT = 4'h3;
	localparam logic [3:0] ACS_OFS_IRQ_MASK = 4'h4;
	localparam logic [3:0] ACS_OFS_CFG = 4'h5;
	localparam logic [3:0] ACS_OFS_FLAGS = 4'h6;

	// ****************************************************************
	// acknowledge word bit positions
	// ****************************************************************
	localparam int ACS_ACK_ABS = 0;
	localparam int ACS_ACK_REL = 1;
	localparam int ACS_ACK_SPEED = 2;
	localparam int ACS_ACK_INT_FEED = 5;
	localparam int ACS_ACK_LATCH_EN = 6;
	localparam int ACS_ACK_PRESET = 7;
	localparam int ACS_ACK_SYNC_POS = 8;
	localparam int ACS_ACK_SYNC_VEL = 9;
	localparam int ACS_ACK_SYNC_TRQ = 10;
	localparam int ACS_ACK_ORG_LATCH = 11;
	localparam int ACS_ACK_CAM = 12;
	localparam int ACS_ACK_UNUSED = 13;
	localparam int ACS_ACK_ORG_CLR = 14;
	localparam int ACS_ACK_LATCH_CLR = 15;

	// bits that exist in the acknowledge word
	localparam logic [15:0] ACS_ACK_USED_MASK = 16'hdfe7;
	// bits that start axis motion and so are gated by the stop flag
	localparam logic [15:0] ACS_START_MASK = 16'h1727;

	// ****************************************************************
	// command status word bit positions
	// ****************************************************************
	localparam int ACS_ST_BUSY = 0;
	localparam int ACS_ST_JOG_EN = 1;
	localparam int ACS_ST_DIRECT_EN = 2;
	localparam int ACS_ST_UNUSED = 3;

	// ****************************************************************
	// interrupt status / mask bit positions
	// ****************************************************************
	localparam int ACS_IRQ_W = 3;
	localparam int ACS_IRQ_ACK = 0;
	localparam int ACS_IRQ_REFUSED = 1;
	localparam int ACS_IRQ_BUSY_END = 2;

	// ****************************************************************
	// configuration and internal flag bit positions
	// ****************************************************************
	localparam int ACS_CFG_MEM_OP = 0;
	localparam int ACS_CFG_ASSIGNED = 1;
	localparam int ACS_FLG_STOP = 0;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [15:0] ACS_RST_WORD = 16'h0000;
	localparam logic [2:0] ACS_RST_IRQ = 3'h0;
	localparam logic [1:0] ACS_RST_CFG = 2'h2;

endpackage : acs_pkg

// ==== logic/acs_sync2.sv ====
`timescale 1ns/10ps
// ****************************************************************
// two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module acs_sync2 #(
	parameter int WIDTH = 2
) (
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta <= '0;
			sync_o <= '0;
		end else if (ce_i) begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

endmodule : acs_sync2

// ==== logic/acs_status.sv ====
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - A latch-enable or interrupt-mask command sets acknowledge bit 6.
// - A present position preset command sets acknowledge bit 7.
// - Synchronous feeding in position, velocity and torque form set bits 8, 9 and 10.
// - An origin position latch enable command sets acknowledge bit 11.
// - An electronic cam start command sets acknowledge bit 12.
// - A clear of the origin latch completion flag sets acknowledge bit 14.
// - A clear of the general latch completion flag sets acknowledge bit 15.
// - Status bit 0 is high for as long as the axis is operating.
// - In memory operation an axis not assigned in the configuration reads as busy.
// - Status bit 1 is high whenever a jog could be started.
// - Status bit 2 is high whenever direct operation could be started.
// - Absolute move, relative move and speed control set acknowledge bits 0, 1 and 2.
// - While the stop flag is high no start command is acknowledged.
module acs_status
	import acs_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// register port
	input wire logic [ACS_ADDR_W-1:0] addr_i,
	input wire logic [ACS_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [ACS_DATA_W-1:0] rdata_o,
	// axis state from motion logic
	input wire logic axis_moving_i,
	input wire logic servo_locked_i,
	input wire logic axis_error_i,
	input wire logic stop_ack_i,
	// stop pins, asynchronous
	input wire logic estop_pin_i,
	input wire logic decel_pin_i,
	// status words and interrupt
	output logic [ACS_DATA_W-1:0] ack_word_o,
	output logic [ACS_DATA_W-1:0] status_word_o,
	output logic irq_o
);

	// ****************************************************************
	// registers and internal signals
	// ****************************************************************
	logic [ACS_DATA_W-1:0] cmd;
	logic [ACS_DATA_W-1:0] ack;
	logic [ACS_DATA_W-1:0] next_ack;
	logic [ACS_DATA_W-1:0] allowed;
	logic [ACS_DATA_W-1:0] status;
	logic [ACS_DATA_W-1:0] next_status;
	logic [ACS_IRQ_W-1:0] irq_stat;
	logic [ACS_IRQ_W-1:0] irq_mask;
	logic [ACS_IRQ_W-1:0] irq_set;
	logic [1:0] cfg;
	logic [1:0] pins_s;
	logic stop_flag;
	logic busy_now;
	logic jog_ok;
	logic direct_ok;
	logic start_ok;
	logic wr_cmd;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic wr_cfg;

	assign wr_cmd = wr_i && (addr_i == ACS_OFS_CMD);
	assign wr_irq_stat = wr_i && (addr_i == ACS_OFS_IRQ_STAT);
	assign wr_irq_mask = wr_i && (addr_i == ACS_OFS_IRQ_MASK);
	assign wr_cfg = wr_i && (addr_i == ACS_OFS_CFG);

	// ****************************************************************
	// stop pin synchronisation
	// ****************************************************************
	acs_sync2 #(
		.WIDTH(2)
	) u_pin_sync (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.async_i({decel_pin_i, estop_pin_i}),
		.sync_o(pins_s)
	);

	// stop flag follows an acknowledged stop bit or either stop pin
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stop_flag <= 1'b0;
		end else if (ce_i) begin
			stop_flag <= stop_ack_i | (|pins_s);
		end
	end

	// ****************************************************************
	// command word, written by the controller
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd <= ACS_RST_WORD;
		end else if (ce_i && wr_cmd) begin
			cmd <= wdata_i;
		end
	end

	// ****************************************************************
	// axis readiness
	// ****************************************************************
	// unassigned axes look busy in memory operation so no one starts them
	assign busy_now = axis_moving_i | (cfg[ACS_CFG_MEM_OP] & ~cfg[ACS_CFG_ASSIGNED]);
	assign jog_ok = ~busy_now & servo_locked_i & ~axis_error_i & ~stop_flag;
	assign direct_ok = ~busy_now & servo_locked_i & ~axis_error_i & ~stop_flag;
	assign start_ok = direct_ok & ~stop_flag;

	// ****************************************************************
	// acknowledge bits, one per command bit
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < ACS_DATA_W; gi++) begin : g_ack
			if (ACS_ACK_USED_MASK[gi]) begin : g_used
				// start bits wait for a ready axis, others are taken at once
				assign allowed[gi] = ACS_START_MASK[gi] ? start_ok : 1'b1;
				// held while the command stays, dropped when it goes
				assign next_ack[gi] = ack[gi] ? cmd[gi] : (cmd[gi] & allowed[gi]);
			end else begin : g_unused
				assign allowed[gi] = 1'b0;
				assign next_ack[gi] = 1'b0;
			end
		end
	endgenerate

	// bits 0-2, 5-12, 14, 15 all land here through the loop above
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack <= ACS_RST_WORD;
		end else if (ce_i) begin
			ack <= next_ack;
		end
	end

	assign ack_word_o = ack;

	// ****************************************************************
	// command status word
	// ****************************************************************
	always_comb begin
		next_status = ACS_RST_WORD;
		next_status[ACS_ST_BUSY] = busy_now;
		next_status[ACS_ST_JOG_EN] = jog_ok;
		next_status[ACS_ST_DIRECT_EN] = direct_ok;
		next_status[ACS_ST_UNUSED] = 1'b0;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status <= ACS_RST_WORD;
		end else if (ce_i) begin
			status <= next_status;
		end
	end

	assign status_word_o = status;

	// ****************************************************************
	// configuration
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg <= ACS_RST_CFG;
		end else if (ce_i && wr_cfg) begin
			cfg <= wdata_i[1:0];
		end
	end

	// ****************************************************************
	// interrupts
	// ****************************************************************
	always_comb begin
		irq_set = ACS_RST_IRQ;
		irq_set[ACS_IRQ_ACK] = |(next_ack & ~ack);
		irq_set[ACS_IRQ_REFUSED] = |(cmd & ACS_START_MASK & ~ack) & stop_flag;
		irq_set[ACS_IRQ_BUSY_END] = status[ACS_ST_BUSY] & ~busy_now;
	end

	// a set in the same cycle as a write-one clear wins
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat <= ACS_RST_IRQ;
		end else if (ce_i) begin
			if (wr_irq_stat) begin
				irq_stat <= (irq_stat & ~wdata_i[ACS_IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat <= irq_stat | irq_set;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_mask <= ACS_RST_IRQ;
		end else if (ce_i && wr_irq_mask) begin
			irq_mask <= wdata_i[ACS_IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ****************************************************************
	// read port: data only in the cycle after the strobe
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= ACS_RST_WORD;
		end else if (ce_i) begin
			rdata_o <= ACS_RST_WORD;
			if (rd_i) begin
				unique case (addr_i)
					ACS_OFS_CMD: begin
						rdata_o <= cmd;
					end
					ACS_OFS_ACK: begin
						rdata_o <= ack;
					end
					ACS_OFS_STATUS: begin
						rdata_o <= status;
					end
					ACS_OFS_IRQ_STAT: begin
						rdata_o <= {13'h0000, irq_stat};
					end
					ACS_OFS_IRQ_MASK: begin
						rdata_o <= {13'h0000, irq_mask};
					end
					ACS_OFS_CFG: begin
						rdata_o <= {14'h0000, cfg};
					end
					ACS_OFS_FLAGS: begin
						rdata_o <= {15'h0000, stop_flag};
					end
					default: begin
						rdata_o <= ACS_RST_WORD;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_latch_en_ack;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && cmd[ACS_ACK_LATCH_EN] && !ack[ACS_ACK_LATCH_EN] |=> ack[ACS_ACK_LATCH_EN];
	endproperty
	a_latch_en_ack: assert property (p_latch_en_ack) else $error("bit 6 not acknowledged");

	property p_preset_ack;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !ack[ACS_ACK_PRESET] ##1 ce_i && cmd[ACS_ACK_PRESET] |=> ack[ACS_ACK_PRESET];
	endproperty
	a_preset_ack: assert property (p_preset_ack) else $error("bit 7 not acknowledged");

	property p_sync_feed_ack;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && start_ok && cmd[ACS_ACK_SYNC_VEL] |=> ack[ACS_ACK_SYNC_VEL];
	endproperty
	a_sync_feed_ack: assert property (p_sync_feed_ack) else $error("bit 9 not acknowledged");

	property p_org_latch_ack;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && cmd[ACS_ACK_ORG_LATCH] |=> ack[ACS_ACK_ORG_LATCH];
	endproperty
	a_org_latch_ack: assert property (p_org_latch_ack) else $error("bit 11 not acknowledged");

	property p_cam_ack;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && start_ok && cmd[ACS_ACK_CAM] |=> ack[ACS_ACK_CAM];
	endproperty
	a_cam_ack: assert property (p_cam_ack) else $error("bit 12 not acknowledged");

	property p_clear_acks;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && cmd[ACS_ACK_ORG_CLR] && cmd[ACS_ACK_LATCH_CLR]
			|=> ack[ACS_ACK_ORG_CLR] && ack[ACS_ACK_LATCH_CLR];
	endproperty
	a_clear_acks: assert property (p_clear_acks) else $error("bits 14/15 not acknowledged");

	property p_busy;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i |=> status_word_o[ACS_ST_BUSY] == $past(busy_now);
	endproperty
	a_busy: assert property (p_busy) else $error("busy bit wrong");

	property p_unassigned_busy;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && cfg[ACS_CFG_MEM_OP] && !cfg[ACS_CFG_ASSIGNED] |=> status_word_o[ACS_ST_BUSY];
	endproperty
	a_unassigned_busy: assert property (p_unassigned_busy) else $error("unassigned axis idle");

	property p_enables;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i |=> status_word_o[ACS_ST_JOG_EN] == $past(jog_ok)
			&& status_word_o[ACS_ST_DIRECT_EN] == $past(direct_ok);
	endproperty
	a_enables: assert property (p_enables) else $error("enable bits wrong");

	property p_move_ack;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && start_ok && cmd[ACS_ACK_ABS] && cmd[ACS_ACK_SPEED]
			|=> ack[ACS_ACK_ABS] && ack[ACS_ACK_SPEED];
	endproperty
	a_move_ack: assert property (p_move_ack) else $error("move bits not acknowledged");

	property p_stop_blocks;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && stop_flag |=> ((ack & ~$past(ack) & ACS_START_MASK) == 16'h0000);
	endproperty
	a_stop_blocks: assert property (p_stop_blocks) else $error("start taken under stop");

	property p_unused_zero;
		@(posedge mclk_i) disable iff (!arst_n_i)
		!ack_word_o[ACS_ACK_UNUSED] && !status_word_o[ACS_ST_UNUSED];
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

	property p_ack_drops;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i |=> ((ack & ~$past(cmd)) == 16'h0000);
	endproperty
	a_ack_drops: assert property (p_ack_drops) else $error("ack without command");

	// a low enable must hold every word, not only the bus side
	property p_ce_freeze;
		@(posedge mclk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(ack) && $stable(status) && $stable(cmd);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

	property p_read_idle;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && !rd_i |=> rdata_o == ACS_RST_WORD;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside its cycle");

	property p_irq_sticky;
		@(posedge mclk_i) disable iff (!arst_n_i)
		ce_i && irq_set[ACS_IRQ_ACK] |=> irq_stat[ACS_IRQ_ACK];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("ack event lost");

endmodule : acs_status

// ==== verification/acs_cpu_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// controller model: owns the register port, holds commands until acknowledged
// ****************************************************************
module acs_cpu_model
	import acs_pkg::*;
(
	// clock
	input wire logic mclk_i,
	// register port
	output logic [ACS_ADDR_W-1:0] addr_o,
	output logic [ACS_DATA_W-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	// acknowledge word and handshake failure
	input wire logic [ACS_DATA_W-1:0] ack_i,
	output logic timeout_o
);
	initial begin
		addr_o = 4'h0;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
		timeout_o = 1'b0;
	end
	// idle bus shows the inverse so a stale value is never mistaken for a live one
	task automatic write_word(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : write_word
	task automatic read_word(input logic [3:0] a);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
	endtask : read_word
	task automatic handshake(input logic [15:0] bits);
		int n;
		write_word(ACS_OFS_CMD, bits);
		n = 0;
		// look at the acknowledge word where it has settled, not at the edge that moves it
		while (((ack_i & bits) !== bits) && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		if (n == 20) timeout_o = 1'b1;
		write_word(ACS_OFS_CMD, 16'h0000);
		n = 0;
		while (((ack_i & bits) !== 16'h0000) && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		if (n == 20) timeout_o = 1'b1;
	endtask : handshake
endmodule : acs_cpu_model

// ==== verification/axis_cmd_ack_status_words_bench.sv ====
`timescale 1ns/10ps
module axis_cmd_ack_status_words_bench
	import acs_pkg::*;
;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic moving = 1'b0, locked = 1'b0, err = 1'b0, stop = 1'b0, estop = 1'b0, decel = 1'b0;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, ack_w, st_w, r;
	logic wr, rd, irq, tmo, rd_seen = 1'b0, ce = 1'b1;
	logic [15:0] exp_q[$];
	int errors = 0, compares = 0, seed = 32'h8cef;
	int bits[16] = '{0, 1, 2, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15, 3, 4, 13};
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	acs_status acs_status_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.axis_moving_i(moving), .servo_locked_i(locked), .axis_error_i(err),
		.stop_ack_i(stop), .estop_pin_i(estop), .decel_pin_i(decel),
		.ack_word_o(ack_w), .status_word_o(st_w), .irq_o(irq));
	acs_cpu_model acs_cpu_model_i (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .ack_i(ack_w), .timeout_o(tmo));
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdx(input logic [3:0] a, input logic [15:0] exp);
		exp_q.push_back(exp);
		acs_cpu_model_i.read_word(a);
	endtask : rdx
	task automatic wrx(input logic [3:0] a, input logic [15:0] d);
		acs_cpu_model_i.write_word(a, d);
	endtask : wrx
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : cyc
	// ****************************************************************
	// read data monitor: oldest note against the word in the cycle after the strobe
	// ****************************************************************
	always @(posedge mclk_i) rd_seen <= rd;
	always @(negedge mclk_i) begin
		if (rd_seen === 1'b1) begin
			if (exp_q.size() == 0) chk(rdata, 16'hxxxx);
			else chk(rdata, exp_q.pop_front());
		end
	end
	initial begin
		#(40 * 20000);
		errors++;
		end_of_test();
	end
	initial begin
		cyc(8);
		arst_n_i <= 1'b1;
		rdx(ACS_OFS_ACK, 16'h0000);
		rdx(ACS_OFS_STATUS, 16'h0000);
		rdx(ACS_OFS_CFG, 16'h0002);
		rdx(ACS_OFS_IRQ_MASK, 16'h0000);
		rdx(4'hf, 16'h0000);
		wrx(ACS_OFS_ACK, 16'hffff);
		rdx(ACS_OFS_ACK, 16'h0000);
		locked <= 1'b1;
		cyc(3);
		rdx(ACS_OFS_STATUS, 16'h0006);
		@(negedge mclk_i);
		chk(st_w, 16'h0006);
		foreach (bits[i]) begin
			r = (bits[i] inside {3, 4, 13}) ? 16'h0000 : 16'h0001 << bits[i];
			wrx(ACS_OFS_CMD, 16'h0001 << bits[i]);
			cyc(2);
			rdx(ACS_OFS_ACK, r);
			@(negedge mclk_i);
			chk(ack_w, r);
			wrx(ACS_OFS_CMD, 16'h0000);
			cyc(2);
			rdx(ACS_OFS_ACK, 16'h0000);
		end
		wrx(ACS_OFS_CMD, 16'hffff);
		cyc(2);
		rdx(ACS_OFS_ACK, 16'hffff & ~16'h2018);
		wrx(ACS_OFS_CMD, 16'h0000);
		acs_cpu_model_i.handshake(16'h0080);
		chk({15'h0, tmo}, 16'h0000);
		wrx(ACS_OFS_IRQ_STAT, 16'h0007);
		stop <= 1'b1;
		cyc(3);
		rdx(ACS_OFS_FLAGS, 16'h0001);
		wrx(ACS_OFS_CMD, 16'h0041);
		cyc(3);
		rdx(ACS_OFS_ACK, 16'h0040);
		rdx(ACS_OFS_IRQ_STAT, 16'h0003);
		stop <= 1'b0;
		cyc(3);
		rdx(ACS_OFS_ACK, 16'h0041);
		wrx(ACS_OFS_CMD, 16'h0000);
		estop <= 1'b1;
		cyc(4);
		rdx(ACS_OFS_FLAGS, 16'h0001);
		estop <= 1'b0;
		decel <= 1'b1;
		cyc(4);
		rdx(ACS_OFS_FLAGS, 16'h0001);
		decel <= 1'b0;
		cyc(4);
		rdx(ACS_OFS_FLAGS, 16'h0000);
		moving <= 1'b1;
		cyc(2);
		rdx(ACS_OFS_STATUS, 16'h0001);
		@(negedge mclk_i);
		chk(st_w, 16'h0001);
		moving <= 1'b0;
		err <= 1'b1;
		cyc(2);
		rdx(ACS_OFS_STATUS, 16'h0000);
		// ack given, start refused under stop, busy ended: all three sticky
		rdx(ACS_OFS_IRQ_STAT, 16'h0007);
		err <= 1'b0;
		wrx(ACS_OFS_CFG, 16'h0001);
		cyc(2);
		rdx(ACS_OFS_STATUS, 16'h0001);
		wrx(ACS_OFS_CFG, 16'h0003);
		cyc(2);
		rdx(ACS_OFS_STATUS, 16'h0006);
		wrx(ACS_OFS_CFG, 16'h0002);
		wrx(ACS_OFS_IRQ_STAT, 16'h0007);
		wrx(ACS_OFS_IRQ_MASK, 16'h0001);
		cyc(2);
		@(negedge mclk_i);
		chk({15'h0, irq}, 16'h0000);
		wrx(ACS_OFS_CMD, 16'h4000);
		cyc(3);
		@(negedge mclk_i);
		chk({15'h0, irq}, 16'h0001);
		wrx(ACS_OFS_IRQ_MASK, 16'h0000);
		cyc(2);
		@(negedge mclk_i);
		chk({15'h0, irq}, 16'h0000);
		wrx(ACS_OFS_IRQ_MASK, 16'h0001);
		wrx(ACS_OFS_CMD, 16'h0000);
		cyc(2);
		@(negedge mclk_i);
		chk({15'h0, irq}, 16'h0001);
		wrx(ACS_OFS_IRQ_STAT, 16'h0001);
		cyc(2);
		@(negedge mclk_i);
		chk({15'h0, irq}, 16'h0000);
		rdx(ACS_OFS_IRQ_STAT, 16'h0000);
		repeat (4) begin
			r = $random(seed);
			wrx(ACS_OFS_IRQ_MASK, r);
			rdx(ACS_OFS_IRQ_MASK, r & 16'h0007);
		end
		// with the enable low a command write must not land
		ce <= 1'b0;
		wrx(ACS_OFS_CMD, 16'h0040);
		cyc(2);
		@(negedge mclk_i);
		chk(ack_w, 16'h0000);
		cyc(1);
		ce <= 1'b1;
		rdx(ACS_OFS_CMD, 16'h0000);
		wrx(ACS_OFS_CMD, 16'h8000);
		cyc(2);
		@(negedge mclk_i);
		chk(ack_w, 16'h8000);
		cyc(1);
		arst_n_i <= 1'b0;
		@(negedge mclk_i);
		chk(ack_w, 16'h0000);
		cyc(2);
		arst_n_i <= 1'b1;
		rdx(ACS_OFS_CMD, 16'h0000);
		rdx(ACS_OFS_ACK, 16'h0000);
		cyc(2);
		end_of_test();
	end
endmodule : axis_cmd_ack_status_words_bench
